//--- logic/pwmcfg_pkg.sv
// Package with register map, field layout and encodings of the PWM auto-switch configuration block
`default_nettype none
package pwmcfg_pkg;

  // Byte addresses inside the module window
  localparam logic [23:0] ADDR_HI_LOWER  = 24'h1D006C;
  localparam logic [23:0] ADDR_LO_UPPER  = 24'h1D0070;
  localparam logic [23:0] ADDR_LO_LOWER  = 24'h1D0074;
  localparam logic [23:0] ADDR_CFG_MAX   = 24'h1D0078;
  localparam logic [23:0] ADDR_HI_UPPER  = 24'h1D0068;

  // Threshold field
  localparam int unsigned THR_LSB = 4;
  localparam int unsigned THR_MSB = 17;
  localparam logic [13:0] THR_RESET = 14'h0000;

  // Configuration field positions
  localparam int unsigned B_SEL_LSB   = 28;
  localparam int unsigned A_SEL_LSB   = 24;
  localparam int unsigned CL_C_BIT    = 23;
  localparam int unsigned CL_AB_BIT   = 20;
  localparam int unsigned CL_PM_BIT   = 19;
  localparam int unsigned FIXED_BIT   = 12;
  localparam int unsigned MODE_LSB    = 4;
  localparam int unsigned ACC_BIT     = 1;
  localparam logic [31:0] CFG_WMASK   = 32'hFF98_10F2;
  localparam logic [31:0] CFG_RESET   = 32'h0000_0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Route selector codes
  typedef enum logic [3:0] {
    ROUTE_PASS  = 4'h0,
    ROUTE_EDGE  = 4'h1,
    ROUTE_LOC_C = 4'h2,
    ROUTE_CROSS = 4'h3,
    ROUTE_DN_A  = 4'h4,
    ROUTE_DN_B  = 4'h5,
    ROUTE_DN_C  = 4'h6,
    ROUTE_DN_C2 = 4'h7,
    ROUTE_DN_C3 = 4'h8
  } pwmcfg_route_e;

  // Operating modes
  typedef enum logic [3:0] {
    MODE_NORMAL = 4'h0,
    MODE_RESON  = 4'h1,
    MODE_MULTI  = 4'h2,
    MODE_TRI    = 4'h3,
    MODE_LEAD   = 4'h4
  } pwmcfg_mode_e;

  // Waveform sources entering the route selectors
  typedef struct packed {
    logic pass_a;
    logic pass_b;
    logic edge_a;
    logic edge_b;
    logic loc_c;
    logic cross_a;
    logic cross_b;
    logic dn_a;
    logic dn_b;
    logic dn_c;
    logic dn_c2;
    logic dn_c3;
  } pwmcfg_src_s;

  // Decoded configuration driving the PWM core
  typedef struct packed {
    pwmcfg_mode_e mode;
    logic         cl_enable;
    logic         pulse_match;
    logic         cl_affects_ab;
    logic         cl_affects_c;
    logic         fixed_duty;
    logic         accel_input;
  } pwmcfg_ctl_s;

endpackage : pwmcfg_pkg
`default_nettype wire

//--- logic/pwmcfg_top.sv
// PWM auto-switch thresholds, mode and output routing configuration with AXI4-Lite slave
//
// Behaviour
// - No mode switch while value sits between high upper and high lower thresholds.
// - No mode switch while value sits between low upper and low lower thresholds.
// - Thresholds are 14-bit fields at bits 17:4, reset zero, low nibble reads zero.
// - Bits 31:28 route output B after edge generation, nine codes, pass at reset.
// - Bits 27:24 route output A before high resolution stage, same nine codes.
// - Bit 23 lets current-limit fault alter output C; clear means ignored.
// - Bit 20 lets current-limit fault alter outputs A and B; clear means ignored.
// - Normal mode: bit 19 enables cycle-by-cycle current limit.
// - Multi and resonant modes: bit 19 enables A/B pulse matching.
// - Resonant mode: bit 12 picks duty from filter (0) or high-switch register (1).
// - Bits 7:4 choose normal, resonant, multi, triangular or leading mode.
// - Bit 1 picks register-driven waveforms (0) or accelerator input (1).
// - Reserved configuration bits read as zero.
`timescale 1ns/1ps
`default_nettype none
module pwmcfg_top (
  input  wire logic                     mclk,
  input  wire logic                     srst,
  // AXI4-Lite slave
  input  wire logic [23:0]              s_awaddr,
  input  wire logic                     s_awvalid,
  output logic                          s_awready,
  input  wire logic [31:0]              s_wdata,
  input  wire logic [3:0]               s_wstrb,
  input  wire logic                     s_wvalid,
  output logic                          s_wready,
  output logic [1:0]                    s_bresp,
  output logic                          s_bvalid,
  input  wire logic                     s_bready,
  input  wire logic [23:0]              s_araddr,
  input  wire logic                     s_arvalid,
  output logic                          s_arready,
  output logic [31:0]                   s_rdata,
  output logic [1:0]                    s_rresp,
  output logic                          s_rvalid,
  input  wire logic                     s_rready,
  // Auto-switch monitoring
  input  wire logic [13:0]              monitor_value,
  input  wire logic [13:0]              high_upper_threshold,
  output logic                          high_switch_allowed,
  output logic                          low_switch_allowed,
  // Waveform routing
  input  wire pwmcfg_pkg::pwmcfg_src_s  route_src,
  input  wire logic                     current_limit_fault,
  output logic                          output_a_routed,
  output logic                          output_b_routed,
  output logic                          cl_fault_to_ab,
  output logic                          cl_fault_to_c,
  // Duty source for resonant mode
  input  wire logic [17:0]              filter_duty,
  output logic [17:0]                   resonant_duty,
  output pwmcfg_pkg::pwmcfg_ctl_s       core_ctl
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [13:0] hi_lower_reg;
  logic [13:0] lo_upper_reg;
  logic [13:0] lo_lower_reg;
  logic [31:0] cfg_reg;
  logic [31:0] cfg_next;

  // Byte-lane merge, used for every writable register
  function automatic logic [31:0] pwmcfg_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : pwmcfg_merge

  // Threshold packing into bits 17:4
  function automatic logic [31:0] pwmcfg_thr_word(input logic [13:0] thr);
    return {14'h0000, thr, 4'h0};
  endfunction : pwmcfg_thr_word

  // Route selector; unlisted codes fall back to pass-through
  function automatic logic pwmcfg_route(input logic [3:0] sel,
                                        input logic pass_v,
                                        input logic edge_v,
                                        input logic cross_v,
                                        input pwmcfg_pkg::pwmcfg_src_s s);
    logic r;
    r = pass_v;
    case (sel)
      pwmcfg_pkg::ROUTE_EDGE:  r = edge_v;
      pwmcfg_pkg::ROUTE_LOC_C: r = s.loc_c;
      pwmcfg_pkg::ROUTE_CROSS: r = cross_v;
      pwmcfg_pkg::ROUTE_DN_A:  r = s.dn_a;
      pwmcfg_pkg::ROUTE_DN_B:  r = s.dn_b;
      pwmcfg_pkg::ROUTE_DN_C:  r = s.dn_c;
      pwmcfg_pkg::ROUTE_DN_C2: r = s.dn_c2;
      pwmcfg_pkg::ROUTE_DN_C3: r = s.dn_c3;
      default:                 r = pass_v;
    endcase
    return r;
  endfunction : pwmcfg_route

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data latched in either order
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [23:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;

  assign s_awready = !aw_held_reg && !bvalid_reg;
  assign s_wready  = !w_held_reg && !bvalid_reg;
  assign s_bvalid  = bvalid_reg;
  assign s_bresp   = bresp_reg;

  wire        aw_fire = s_awvalid && s_awready;
  wire        w_fire  = s_wvalid && s_wready;
  wire        aw_have = aw_held_reg || aw_fire;
  wire        w_have  = w_held_reg || w_fire;
  wire        do_write = aw_have && w_have;
  wire [23:0] wr_addr = aw_held_reg ? aw_addr_reg : s_awaddr;
  wire [31:0] wr_data = w_held_reg ? w_data_reg : s_wdata;
  wire [3:0]  wr_strb = w_held_reg ? w_strb_reg : s_wstrb;

  // Write address decode
  wire wr_hi_lower = (wr_addr == pwmcfg_pkg::ADDR_HI_LOWER);
  wire wr_lo_upper = (wr_addr == pwmcfg_pkg::ADDR_LO_UPPER);
  wire wr_lo_lower = (wr_addr == pwmcfg_pkg::ADDR_LO_LOWER);
  wire wr_cfg      = (wr_addr == pwmcfg_pkg::ADDR_CFG_MAX);
  wire wr_mapped   = wr_hi_lower || wr_lo_upper || wr_lo_lower || wr_cfg;

  // Merged threshold words; low nibble and upper bits never stored
  wire [31:0] hi_lower_m = pwmcfg_merge(pwmcfg_thr_word(hi_lower_reg), wr_data, wr_strb);
  wire [31:0] lo_upper_m = pwmcfg_merge(pwmcfg_thr_word(lo_upper_reg), wr_data, wr_strb);
  wire [31:0] lo_lower_m = pwmcfg_merge(pwmcfg_thr_word(lo_lower_reg), wr_data, wr_strb);

  // Reserved bits masked so they stay zero
  assign cfg_next = pwmcfg_merge(cfg_reg, wr_data, wr_strb) & pwmcfg_pkg::CFG_WMASK;

  // Write handshake state
  always_ff @(posedge mclk) begin
    if (srst) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 24'h000000;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= pwmcfg_pkg::RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_addr_reg <= s_awaddr;
      end
      if (w_fire) begin
        w_data_reg <= s_wdata;
        w_strb_reg <= s_wstrb;
      end
      aw_held_reg <= aw_have && !do_write;
      w_held_reg  <= w_have && !do_write;
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_mapped ? pwmcfg_pkg::RESP_OKAY : pwmcfg_pkg::RESP_SLVERR;
      end else if (s_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Register file updates
  always_ff @(posedge mclk) begin
    if (srst) begin
      hi_lower_reg <= pwmcfg_pkg::THR_RESET;
      lo_upper_reg <= pwmcfg_pkg::THR_RESET;
      lo_lower_reg <= pwmcfg_pkg::THR_RESET;
      cfg_reg      <= pwmcfg_pkg::CFG_RESET;
    end else if (do_write) begin
      if (wr_hi_lower) begin
        hi_lower_reg <= hi_lower_m[pwmcfg_pkg::THR_MSB:pwmcfg_pkg::THR_LSB];
      end
      if (wr_lo_upper) begin
        lo_upper_reg <= lo_upper_m[pwmcfg_pkg::THR_MSB:pwmcfg_pkg::THR_LSB];
      end
      if (wr_lo_lower) begin
        lo_lower_reg <= lo_lower_m[pwmcfg_pkg::THR_MSB:pwmcfg_pkg::THR_LSB];
      end
      if (wr_cfg) begin
        cfg_reg <= cfg_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one cycle to answer, data held until taken
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rd_word;
  logic        rd_ok;

  assign s_arready = !rvalid_reg;
  assign s_rvalid  = rvalid_reg;
  assign s_rdata   = rdata_reg;
  assign s_rresp   = rresp_reg;

  // Read decode; upper threshold is the core's and is not readable here, its address answers SLVERR
  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    if (s_araddr == pwmcfg_pkg::ADDR_HI_LOWER) begin
      rd_word = pwmcfg_thr_word(hi_lower_reg);
    end else if (s_araddr == pwmcfg_pkg::ADDR_LO_UPPER) begin
      rd_word = pwmcfg_thr_word(lo_upper_reg);
    end else if (s_araddr == pwmcfg_pkg::ADDR_LO_LOWER) begin
      rd_word = pwmcfg_thr_word(lo_lower_reg);
    end else if (s_araddr == pwmcfg_pkg::ADDR_CFG_MAX) begin
      rd_word = cfg_reg;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= pwmcfg_pkg::RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_ok ? pwmcfg_pkg::RESP_OKAY : pwmcfg_pkg::RESP_SLVERR;
    end else if (s_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hysteresis bands: switching blocked strictly inside each band
  wire in_high_band = (monitor_value < high_upper_threshold) && (monitor_value > hi_lower_reg);
  wire in_low_band  = (monitor_value < lo_upper_reg) && (monitor_value > lo_lower_reg);
  assign high_switch_allowed = !in_high_band;
  assign low_switch_allowed  = !in_low_band;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode; reserved codes behave as normal mode
  wire [3:0] mode_raw = cfg_reg[pwmcfg_pkg::MODE_LSB +: 4];
  pwmcfg_pkg::pwmcfg_mode_e mode_eff;
  assign mode_eff = (mode_raw > pwmcfg_pkg::MODE_LEAD) ? pwmcfg_pkg::MODE_NORMAL
                                                       : pwmcfg_pkg::pwmcfg_mode_e'(mode_raw);

  wire is_normal = (mode_eff == pwmcfg_pkg::MODE_NORMAL);
  wire is_reson  = (mode_eff == pwmcfg_pkg::MODE_RESON);
  wire pm_mode   = is_reson || (mode_eff == pwmcfg_pkg::MODE_MULTI);
  wire bit19     = cfg_reg[pwmcfg_pkg::CL_PM_BIT];
  wire fixed_sel = cfg_reg[pwmcfg_pkg::FIXED_BIT];

  // Core control fields
  assign core_ctl.mode          = mode_eff;
  assign core_ctl.cl_enable     = is_normal && bit19;
  assign core_ctl.pulse_match   = pm_mode && bit19;
  assign core_ctl.cl_affects_ab = cfg_reg[pwmcfg_pkg::CL_AB_BIT];
  assign core_ctl.cl_affects_c  = cfg_reg[pwmcfg_pkg::CL_C_BIT];
  assign core_ctl.fixed_duty    = is_reson && fixed_sel;
  assign core_ctl.accel_input   = cfg_reg[pwmcfg_pkg::ACC_BIT];

  // Fault gating toward outputs
  assign cl_fault_to_ab = current_limit_fault && cfg_reg[pwmcfg_pkg::CL_AB_BIT];
  assign cl_fault_to_c  = current_limit_fault && cfg_reg[pwmcfg_pkg::CL_C_BIT];

  // Resonant duty source; outside resonant mode the filter duty passes
  assign resonant_duty = (is_reson && fixed_sel) ? {high_upper_threshold, 4'h0} : filter_duty;

  ////////////////////////////////////////////////////////////////////////////
  // Output routing
  wire [3:0] a_sel = cfg_reg[pwmcfg_pkg::A_SEL_LSB +: 4];
  wire [3:0] b_sel = cfg_reg[pwmcfg_pkg::B_SEL_LSB +: 4];
  assign output_a_routed = pwmcfg_route(a_sel, route_src.pass_a, route_src.edge_a,
                                        route_src.cross_a, route_src);
  assign output_b_routed = pwmcfg_route(b_sel, route_src.pass_b, route_src.edge_b,
                                        route_src.cross_b, route_src);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence cfg_write_s;
    do_write && wr_cfg;
  endsequence

  high_band_block_a: assert property (@(posedge mclk) disable iff (srst)
    (monitor_value > hi_lower_reg && monitor_value < high_upper_threshold) |-> !high_switch_allowed)
    else $error("high band switch not blocked");
  low_band_block_a: assert property (@(posedge mclk) disable iff (srst)
    (monitor_value > lo_lower_reg && monitor_value < lo_upper_reg) |-> !low_switch_allowed)
    else $error("low band switch not blocked");
  thr_store_a: assert property (@(posedge mclk) disable iff (srst)
    (do_write && wr_hi_lower && wr_strb == 4'hF) |=> hi_lower_reg == $past(wr_data[17:4]))
    else $error("threshold write lost");
  route_b_a: assert property (@(posedge mclk) disable iff (srst)
    (b_sel == 4'h1) |-> output_b_routed == route_src.edge_b)
    else $error("B route wrong");
  route_a_a: assert property (@(posedge mclk) disable iff (srst)
    (a_sel == 4'h4) |-> output_a_routed == route_src.dn_a)
    else $error("A route wrong");
  fault_c_a: assert property (@(posedge mclk) disable iff (srst)
    !cfg_reg[23] |-> !cl_fault_to_c)
    else $error("C fault not ignored");
  // Enabled C gating must pass the fault, not only block it when clear
  fault_c_pass_a: assert property (@(posedge mclk) disable iff (srst)
    (cfg_reg[23] && current_limit_fault) |-> cl_fault_to_c)
    else $error("C fault not passed");
  fixed_duty_a: assert property (@(posedge mclk) disable iff (srst)
    (mode_raw == 4'h1 && fixed_sel) |-> resonant_duty == {high_upper_threshold, 4'h0})
    else $error("fixed duty not taken");
  fault_ab_a: assert property (@(posedge mclk) disable iff (srst)
    (cfg_reg[20] && current_limit_fault) |-> cl_fault_to_ab)
    else $error("AB fault not passed");
  cl_normal_a: assert property (@(posedge mclk) disable iff (srst)
    (mode_raw == 4'h0 && bit19) |-> core_ctl.cl_enable && !core_ctl.pulse_match)
    else $error("current limit enable wrong");
  pulse_match_a: assert property (@(posedge mclk) disable iff (srst)
    (mode_raw == 4'h2 && bit19) |-> core_ctl.pulse_match)
    else $error("pulse match missing");
  duty_src_a: assert property (@(posedge mclk) disable iff (srst)
    (mode_raw == 4'h1 && !fixed_sel) |-> resonant_duty == filter_duty)
    else $error("duty source wrong");
  mode_follow_a: assert property (@(posedge mclk) disable iff (srst)
    cfg_write_s ##1 (mode_raw == 4'h3) |-> core_ctl.mode == pwmcfg_pkg::MODE_TRI)
    else $error("mode not applied");
  accel_sel_a: assert property (@(posedge mclk) disable iff (srst)
    (core_ctl.accel_input == cfg_reg[1]) and (cfg_write_s |=> cfg_reg[1] == $past(cfg_next[1])))
    else $error("accelerator enable wrong");
  reserved_zero_a: assert property (@(posedge mclk) disable iff (srst)
    (cfg_reg & ~pwmcfg_pkg::CFG_WMASK) == 32'h0000_0000)
    else $error("reserved bits set");
  unused_code_a: assert property (@(posedge mclk) disable iff (srst)
    (mode_raw > 4'h4) |-> core_ctl.mode == pwmcfg_pkg::MODE_NORMAL)
    else $error("unused mode not normal");

endmodule : pwmcfg_top
`default_nettype wire

//--- verification/pwmcfg_tb.sv
// Self-checking bench for the PWM auto-switch, routing and mode configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module pwmcfg_tb;
  typedef struct { string nm; int kind; logic [63:0] v; } pwmcfg_exp_s;
  logic                    mclk, srst, probe_go;
  logic [23:0]             s_awaddr, s_araddr;
  logic                    s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic                    s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [31:0]             s_wdata, s_rdata;
  logic [3:0]              s_wstrb;
  logic [1:0]              s_bresp, s_rresp;
  logic [13:0]             monitor_value, high_upper_threshold;
  logic                    high_switch_allowed, low_switch_allowed, output_a_routed, output_b_routed;
  logic                    cl_fault_to_ab, cl_fault_to_c, current_limit_fault;
  logic [17:0]             filter_duty, resonant_duty;
  pwmcfg_pkg::pwmcfg_src_s route_src;
  pwmcfg_pkg::pwmcfg_ctl_s core_ctl;
  pwmcfg_exp_s             exp_q[$];
  int                      n_mismatch, n_tests;
  localparam logic [23:0]  CFG = pwmcfg_pkg::ADDR_CFG_MAX;
  localparam logic [23:0]  ADR[4] = '{pwmcfg_pkg::ADDR_HI_LOWER, pwmcfg_pkg::ADDR_LO_UPPER,
                                      pwmcfg_pkg::ADDR_LO_LOWER, pwmcfg_pkg::ADDR_CFG_MAX};

  pwmcfg_top pwmcfg_top_inst (
    .mclk(mclk), .srst(srst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .monitor_value(monitor_value), .high_upper_threshold(high_upper_threshold),
    .high_switch_allowed(high_switch_allowed), .low_switch_allowed(low_switch_allowed),
    .route_src(route_src), .current_limit_fault(current_limit_fault), .output_a_routed(output_a_routed),
    .output_b_routed(output_b_routed), .cl_fault_to_ab(cl_fault_to_ab), .cl_fault_to_c(cl_fault_to_c),
    .filter_duty(filter_duty), .resonant_duty(resonant_duty), .core_ctl(core_ctl)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 100 ns period
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Expected result notes, oldest first
  task automatic note(string nm, int kind, logic [63:0] v);
    exp_q.push_back('{nm, kind, v});
  endtask : note

  // AXI4-Lite write; bready held until the response is seen
  task automatic axw(logic [23:0] a, logic [31:0] d, logic [3:0] st, logic [1:0] er);
    note("bresp", 0, 64'(er));
    s_awaddr  <= a;
    s_wdata   <= d;
    s_wstrb   <= st;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(posedge mclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) break;
    end
    s_bready <= 1'b0;
    // Idle edge keeps strobes from being driven twice in one step
    @(posedge mclk);
  endtask : axw

  // AXI4-Lite read; expectation is {rresp, rdata}
  task automatic axr(logic [23:0] a, logic [33:0] ex);
    note("rdata", 1, 64'(ex));
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(posedge mclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) break;
    end
    s_rready <= 1'b0;
    @(posedge mclk);
  endtask : axr

  // Sample combinational outputs one edge after inputs settle
  task automatic probe(string nm, int kind, logic [63:0] v);
    note(nm, kind, v);
    probe_go <= 1'b1;
    @(posedge mclk);
    probe_go <= 1'b0;
    @(posedge mclk);
  endtask : probe

  // Reference selector; unused codes fall back to pass-through
  function automatic logic route(logic [3:0] c, logic p, logic g, logic x, pwmcfg_pkg::pwmcfg_src_s s);
    case (c)
      4'h1: return g;
      4'h2: return s.loc_c;
      4'h3: return x;
      4'h4: return s.dn_a;
      4'h5: return s.dn_b;
      4'h6: return s.dn_c;
      4'h7: return s.dn_c2;
      4'h8: return s.dn_c3;
      default: return p;
    endcase
  endfunction : route

  // Reference decode of the configuration word
  function automatic logic [63:0] ctl_exp(logic [31:0] r);
    pwmcfg_pkg::pwmcfg_ctl_s e;
    logic [3:0]              m;
    m = (r[7:4] > 4'h4) ? 4'h0 : r[7:4];
    e.mode = pwmcfg_pkg::pwmcfg_mode_e'(m);
    e.cl_enable = r[19] && (m == 4'h0);
    e.pulse_match = r[19] && (m == 4'h1 || m == 4'h2);
    e.cl_affects_ab = r[20];
    e.cl_affects_c = r[23];
    e.fixed_duty = r[12] && (m == 4'h1);
    e.accel_input = r[1];
    return 64'(e);
  endfunction : ctl_exp

  ////////////////////////////////////////////////////////////////////////////////
  // Monitor: pops the oldest note whenever a result shows up
  always @(posedge mclk) begin
    pwmcfg_exp_s e;
    logic [63:0] got;
    if ((s_bvalid && s_bready) || (s_rvalid && s_rready) || probe_go) begin
      e = exp_q.pop_front();
      case (e.kind)
        0: got = 64'(s_bresp);
        1: got = 64'({s_rresp, s_rdata});
        2: got = 64'({high_switch_allowed, low_switch_allowed});
        3: got = 64'({output_a_routed, output_b_routed});
        4: got = 64'({cl_fault_to_ab, cl_fault_to_c});
        5: got = 64'(resonant_duty);
        default: got = 64'(core_ctl);
      endcase
      `CHK(e.nm, e.v, got)
    end
  end

  // Verdict; leftover notes mean a result never arrived
  task automatic finish_test();
    if (exp_q.size() != 0) n_mismatch++;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    $display("watchdog expired");
    n_mismatch++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0]             d, cfg;
    logic [13:0]             mv;
    pwmcfg_pkg::pwmcfg_src_s s;
    int                      tv[8] = '{100, 101, 199, 200, 20, 21, 49, 50};
    {srst, probe_go} = 2'h3;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, current_limit_fault} = '0;
    {monitor_value, high_upper_threshold, filter_duty} = '0;
    route_src = '0;
    probe_go = 1'b0;
    void'($urandom(32'hF34748A5));
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    // Reset values of every register
    for (int i = 0; i < 4; i++) axr(ADR[i], 34'h0);
    $display("test reset done");
    // Threshold fields keep bits 17:4 only
    for (int i = 0; i < 3; i++) begin
      d = $urandom;
      axw(ADR[i], d, 4'hF, pwmcfg_pkg::RESP_OKAY);
      axr(ADR[i], {16'h0000, d[17:4], 4'h0});
    end
    // Reserved config bits, then a single byte lane
    d = $urandom;
    axw(CFG, d, 4'hF, pwmcfg_pkg::RESP_OKAY);
    cfg = d & 32'hFF98_10F2;
    axr(CFG, {2'h0, cfg});
    d = $urandom;
    axw(CFG, d, 4'h2, pwmcfg_pkg::RESP_OKAY);
    cfg[15:8] = d[15:8] & 8'h10;
    axr(CFG, {2'h0, cfg});
    // Unmapped word is refused
    axw(pwmcfg_pkg::ADDR_HI_UPPER, $urandom, 4'hF, pwmcfg_pkg::RESP_SLVERR);
    axr(pwmcfg_pkg::ADDR_HI_UPPER, {pwmcfg_pkg::RESP_SLVERR, 32'h0});
    $display("test registers done");
    // Hysteresis bands, edges then random values
    axw(ADR[0], 32'd100 << 4, 4'hF, pwmcfg_pkg::RESP_OKAY);
    axw(ADR[1], 32'd50 << 4, 4'hF, pwmcfg_pkg::RESP_OKAY);
    axw(ADR[2], 32'd20 << 4, 4'hF, pwmcfg_pkg::RESP_OKAY);
    high_upper_threshold <= 14'd200;
    for (int k = 0; k < 24; k++) begin
      mv = (k < 8) ? 14'(tv[k]) : 14'($urandom_range(0, 255));
      monitor_value <= mv;
      probe("switch", 2, {62'h0, !(mv > 100 && mv < 200), !(mv > 20 && mv < 50)});
    end
    $display("test hysteresis done");
    // Every selector code on both outputs, unused codes included
    for (int c = 0; c < 16; c++) begin
      s = pwmcfg_pkg::pwmcfg_src_s'(12'($urandom));
      route_src <= s;
      axw(CFG, {4'(15 - c), 4'(c), 24'h0}, 4'hF, pwmcfg_pkg::RESP_OKAY);
      probe("route", 3, {62'h0, route(4'(c), s.pass_a, s.edge_a, s.cross_a, s),
                         route(4'(15 - c), s.pass_b, s.edge_b, s.cross_b, s)});
    end
    $display("test routing done");
    // All mode codes, shared bit 19 and duty select forced both ways
    for (int k = 0; k < 32; k++) begin
      cfg = ($urandom & 32'h0090_0002) | (k[4] ? 32'h0008_1000 : 32'h0) | (32'(k[3:0]) << 4);
      d = $urandom;
      filter_duty <= d[17:0];
      high_upper_threshold <= d[31:18];
      current_limit_fault <= cfg[1] ^ k[0];
      axw(CFG, cfg, 4'hF, pwmcfg_pkg::RESP_OKAY);
      probe("core_ctl", 6, ctl_exp(cfg));
      probe("cl_fault", 4, {62'h0, (cfg[1] ^ k[0]) & cfg[20], (cfg[1] ^ k[0]) & cfg[23]});
      probe("duty", 5, 64'((k[3:0] == 4'h1 && cfg[12]) ? {d[31:18], 4'h0} : d[17:0]));
    end
    $display("test modes done");
    finish_test();
  end
endmodule : pwmcfg_tb
`default_nettype wire
